// ### design/ring_wake_map.vh
// Register map, field positions and timing constants of the ring and wake logic
`ifndef RING_WAKE_MAP_VH
`define RING_WAKE_MAP_VH
`define OFS_POWER       7'h3e
`define OFS_STICKY      7'h50
`define OFS_WAKE_MASK   7'h52
`define OFS_PIN_STATUS  7'h54
`define OFS_LINE_CTL    7'h5c
`define OFS_RING_STAT   7'h5e
`define OFS_LINE_CTL2   7'h62
`define LC_RINGZ        0
`define LC_THRESH       1
`define LC_FULLWAVE     2
`define LC_SLEW         3
`define LC_DCT_LO       4
`define LC_DCT_HI       5
`define LC_RESET        16'h0020
`define LC2_HEADROOM    0
`define LC2_NOATTEN     1
`define LC2_RESET       16'h0000
`define RS_POS          0
`define RS_NEG          1
`define RS_LCS_LO       4
`define RS_LCS_HI       7
`define PWR_LINK_DOWN   12
`define PWR_READY       8'h0f
`define GPIO_OFFHOOK    4
`define GPIO_MONITOR    6
`define STAT_LINE_A     1
`define TAG_READY       15
`define TAG_SLOT1       14
`define TAG_SLOT2       13
`define TAG_SLOT5       10
`define TAG_SLOT12      3
`define SLOT_IDLE       4'hd
`define TAG_LAST_BIT    5'h0f
`define SLOT_LAST_BIT   5'h13
`define DCT_LOWVOLT     2'h1
`define DCT_STANDARD    2'h2
`define DCT_CURLIMIT    2'h3
`define LCS_HEADROOM    4'h6
`define SAMPLE_HIGH     16'h7fff
`define SAMPLE_LOW      16'h8000
`define SAMPLE_REST     16'h04cc
`define ONESHOT_FRAMES  65536
`define CLK_PERIOD_NS   5
`define SLEW_RAMP_NS    20000
`define SLEW_RAMP_CYC   12'hfa0
`endif

// ### design/ring_detect_wake_logic.v
// Ring detection, wake-on-ring and line control behind the serial codec link
`timescale 1ns/1ps
`include "ring_wake_map.vh"
// Summary of operation
// (RULE1) Threshold select bit drives threshold output
// (RULE2) Ring shown in slot12, status flags, stream
// (RULE3) Full-wave bit clear: positive detection only
// (RULE4) Full-wave bit set: positive or negative
// (RULE5) Half-wave slot bit: retriggerable 65536-frame one-shot
// (RULE6) Negative ring never sets half-wave bit
// (RULE7) Off-hook clears one-shot bit at once
// (RULE8) Full-wave slot bit active low beyond thresholds
// (RULE9) Flags follow positive and negative comparisons
// (RULE10) Stream only when link up, on-hook, unmonitored
// (RULE11) Half-wave samples: low unless ring positive
// (RULE12) Full-wave samples: rest, high, or low
// (RULE13) Sample sign bit toggles at ring frequency
// (RULE14) Controller measures ring frequency
// (RULE15) Ringer impedance bit enables synthesized impedance
// (RULE16) Low power: ring raises serial input
// (RULE17) Serial input held high until warm reset
// (RULE18) Controller checks ready and wake status
// (RULE19) Driver arms sticky and mask, clears status
// (RULE20) Cold reset wake needs sticky reprogramming
// (RULE21) Headroom only in current-limit, low loop current
// (RULE22) Low-voltage mode attenuates; flag skips attenuation
// (RULE23) Slew bit ramps loop current at on-hook
// (RULE24) Controller pulses hook at ten per second
// (RULE25) Controller sets off-hook via slot12 bit
// (RULE26) Termination field selects low, standard, limit
// (RULE27) Ring bit and flags refreshed every frame
module ring_detect_wake_logic #(
	parameter ONESHOT_FRAMES = `ONESHOT_FRAMES
) (
	// Clock and reset
	input  wire       CLK,
	input  wire       RESETN,
	input  wire       CE,
	// Serial codec link
	input  wire       BIT_CLK,
	input  wire       SYNC,
	input  wire       SDATA_OUT,
	output reg        SDATA_IN,
	// Line side sense
	input  wire       RING_POS,
	input  wire       RING_NEG,
	input  wire [3:0] LOOP_CURRENT,
	// Line side control
	output reg        OFF_HOOK,
	output reg        LINE_MONITOR,
	output reg        THRESH_SEL,
	output reg        RINGER_Z,
	output reg  [1:0] DC_TERM,
	output reg        LOWVOLT_MODE,
	output reg        TX_ATTEN,
	output reg        HEADROOM_BOOST,
	output reg        SLEW_RAMP
);

	// Two-stage capture of every asynchronous input
	// The bit clock is slow enough that three clocks of lag cost nothing
	wire [8:0]  raw = {BIT_CLK, SYNC, SDATA_OUT, RING_POS, RING_NEG, LOOP_CURRENT};
	reg  [8:0]  meta;
	reg  [8:0]  syn;
	reg         bclk_prev;
	reg         sync_fall;

	wire        bclk = syn[8];
	wire        sync = syn[7];
	wire        sdo  = syn[6];
	wire        pos  = syn[5];
	wire        neg  = syn[4];
	wire [3:0]  loop_current_code  = syn[3:0];

	wire        rise   = bclk & ~bclk_prev;
	wire        fall   = ~bclk & bclk_prev;
	wire        fstart = fall & sync & ~sync_fall;

	// Registers
	reg  [15:0] sticky_sel;
	reg  [15:0] wake_mask;
	reg  [15:0] pin_sticky;
	reg  [15:0] line_ctl;
	reg  [15:0] line_ctl2;
	reg  [1:0]  ring_flags;
	reg         link_down;

	// Frame position and inbound slots
	reg  [3:0]  slot;
	reg  [4:0]  sbit;
	reg  [18:0] shreg;
	reg  [15:0] tag_in;
	reg  [19:0] cmd_in;
	reg         rd_pend;
	reg  [6:0]  rd_idx;

	// Outbound frame words
	reg  [15:0] tag_out;
	reg  [19:0] s1_out;
	reg  [19:0] s2_out;
	reg  [19:0] s5_out;
	reg  [19:0] s12_out;

	// Ring state
	reg         ring_bit;
	reg  [16:0] os_cnt;
	reg         wake_hold;
	reg         sync_hi;
	reg  [11:0] ramp_cnt;

	// Two-entry sample buffer
	reg  [15:0] buf_mem [0:1];
	reg         buf_wp;
	reg         buf_rp;
	reg  [1:0]  buf_cnt;

	wire        fullwave = line_ctl[`LC_FULLWAVE];
	wire [1:0]  dc_termination_select      = line_ctl[`LC_DCT_HI:`LC_DCT_LO];
	wire        detect   = pos | (fullwave & neg); // (RULE3) (RULE4) (RULE6)

	// Next frame position
	wire [19:0] word     = {shreg, sdo};
	wire        slot_end = (slot == 4'h0) ? (sbit == `TAG_LAST_BIT) : (sbit == `SLOT_LAST_BIT);
	wire [3:0]  nslot    = slot_end ? slot + 4'h1 : slot;
	wire [4:0]  nsbit    = slot_end ? 5'h00 : sbit + 5'h01;
	wire        nlast    = (nslot == 4'h0) ? (nsbit == `TAG_LAST_BIT) : (nsbit == `SLOT_LAST_BIT);
	wire        advance  = fall & ~fstart & (slot != `SLOT_IDLE);
	wire        take     = advance & nlast;

	// Register write and read decode
	wire        wr_en   = take & (nslot == 4'h2) & tag_in[`TAG_SLOT1] & tag_in[`TAG_SLOT2] & ~cmd_in[19];
	wire        rd_req  = take & (nslot == 4'h2) & tag_in[`TAG_SLOT1] & cmd_in[19];
	wire [6:0]  wr_idx  = cmd_in[18:12];
	wire [15:0] wr_data = word[19:4];

	// Hook control from slot 12
	wire        gpio_ok   = take & (nslot == 4'hc) & tag_in[`TAG_SLOT12];
	wire        hook_rise = gpio_ok & word[`GPIO_OFFHOOK] & ~OFF_HOOK;
	wire        hook_fall = gpio_ok & ~word[`GPIO_OFFHOOK] & OFF_HOOK;

	// Pin status: live level or sticky copy
	wire [15:0] pin_live   = {14'h0000, detect | ring_bit, 1'b0};
	wire [15:0] pin_status = (pin_live & ~sticky_sel) | (pin_sticky & sticky_sel);
	wire [15:0] clr_mask   = (wr_en && wr_idx == `OFS_PIN_STATUS) ? wr_data : 16'hffff;
	wire [15:0] next_sticky = (pin_sticky & clr_mask) | (pin_live & sticky_sel);

	// Ring sample for the stream
	wire [15:0] sample = pos ? `SAMPLE_HIGH :
		(fullwave ? (neg ? `SAMPLE_LOW : `SAMPLE_REST) : `SAMPLE_LOW); // (RULE11) (RULE12) (RULE13)

	// Popping only while the link is usable keeps samples held through a stall
	wire        link_ok   = ~link_down & ~OFF_HOOK & ~LINE_MONITOR; // (RULE10)
	wire        buf_push  = fstart & (buf_cnt != 2'h2);
	wire        buf_pop   = fstart & link_ok & (buf_cnt != 2'h0);
	// Wake looks at sticky status so a short ring burst is not missed
	wire        wake_want = link_down & ((pin_status & wake_mask) != 16'h0000);

	reg  [15:0] rd_data;
	reg         out_bit;

	// Read mux
	always @* begin
		case (rd_idx)
			`OFS_POWER:      rd_data = {3'h0, link_down, 4'h0, link_down ? 8'h00 : `PWR_READY};
			`OFS_STICKY:     rd_data = sticky_sel;
			`OFS_WAKE_MASK:  rd_data = wake_mask;
			`OFS_PIN_STATUS: rd_data = pin_status;
			`OFS_LINE_CTL:   rd_data = line_ctl;
			`OFS_RING_STAT:  rd_data = {8'h00, loop_current_code, 2'h0, ring_flags}; // (RULE2)
			`OFS_LINE_CTL2:  rd_data = line_ctl2;
			default:         rd_data = 16'h0000;
		endcase
	end

	// Outbound bit at the current frame position
	always @* begin
		case (slot)
			4'h0:    out_bit = tag_out[4'hf - sbit[3:0]];
			4'h1:    out_bit = s1_out[5'h13 - sbit];
			4'h2:    out_bit = s2_out[5'h13 - sbit];
			4'h5:    out_bit = s5_out[5'h13 - sbit];
			4'hc:    out_bit = s12_out[5'h13 - sbit];
			default: out_bit = 1'b0;
		endcase
	end

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			meta           <= 9'h000;
			syn            <= 9'h000;
			bclk_prev      <= 1'b0;
			sync_fall      <= 1'b0;
			sticky_sel     <= 16'h0000;
			wake_mask      <= 16'h0000;
			pin_sticky     <= 16'h0000; // (RULE20)
			line_ctl       <= `LC_RESET;
			line_ctl2      <= `LC2_RESET;
			ring_flags     <= 2'h0;
			link_down      <= 1'b0;
			slot           <= `SLOT_IDLE;
			sbit           <= 5'h00;
			shreg          <= 19'h00000;
			tag_in         <= 16'h0000;
			cmd_in         <= 20'h00000;
			rd_pend        <= 1'b0;
			rd_idx         <= 7'h00;
			tag_out        <= 16'h0000;
			s1_out         <= 20'h00000;
			s2_out         <= 20'h00000;
			s5_out         <= 20'h00000;
			s12_out        <= 20'h00000;
			ring_bit       <= 1'b0;
			os_cnt         <= 17'h00000;
			wake_hold      <= 1'b0;
			sync_hi        <= 1'b0;
			ramp_cnt       <= 12'h000;
			buf_mem[0]     <= 16'h0000;
			buf_mem[1]     <= 16'h0000;
			buf_wp         <= 1'b0;
			buf_rp         <= 1'b0;
			buf_cnt        <= 2'h0;
			SDATA_IN       <= 1'b0;
			OFF_HOOK       <= 1'b0;
			LINE_MONITOR   <= 1'b0;
			THRESH_SEL     <= 1'b0;
			RINGER_Z       <= 1'b0;
			DC_TERM        <= `DCT_STANDARD;
			LOWVOLT_MODE   <= 1'b0;
			TX_ATTEN       <= 1'b0;
			HEADROOM_BOOST <= 1'b0;
			SLEW_RAMP      <= 1'b0;
		end else if (CE) begin
			meta      <= raw;
			syn       <= meta;
			bclk_prev <= bclk;

			// Frame position: link sampled on falling bit clock edges
			if (fall) begin
				sync_fall <= sync;
			end
			if (fstart) begin
				slot  <= 4'h0;
				sbit  <= 5'h00;
				shreg <= {18'h00000, sdo};
			end else if (advance) begin
				slot  <= nslot;
				sbit  <= nsbit;
				shreg <= word[18:0];
			end

			// Completed inbound slots
			if (take && nslot == 4'h0) begin
				tag_in <= word[15:0];
			end
			if (take && nslot == 4'h1) begin
				cmd_in <= word;
			end
			if (rd_req) begin
				rd_pend <= 1'b1;
				rd_idx  <= cmd_in[18:12];
			end
			if (gpio_ok) begin
				OFF_HOOK     <= word[`GPIO_OFFHOOK];
				LINE_MONITOR <= word[`GPIO_MONITOR];
			end

			// Register writes
			if (wr_en) begin
				case (wr_idx)
					`OFS_POWER:     link_down  <= wr_data[`PWR_LINK_DOWN];
					`OFS_STICKY:    sticky_sel <= wr_data;
					`OFS_WAKE_MASK: wake_mask  <= wr_data;
					`OFS_LINE_CTL:  line_ctl   <= wr_data;
					`OFS_LINE_CTL2: line_ctl2  <= wr_data;
					default:        ;
				endcase
			end

			// Sticky status: a new event wins over a clearing write
			pin_sticky <= next_sticky;

			// Frame-rate refresh of flags, slot bit and outbound words
			if (fstart) begin
				ring_flags <= {neg, pos}; // (RULE9) (RULE27)
				if (fullwave) begin
					ring_bit <= ~detect; // (RULE8) (RULE27)
					os_cnt   <= 17'h00000;
				end else if (pos) begin
					os_cnt   <= ONESHOT_FRAMES[16:0]; // (RULE5)
					ring_bit <= 1'b1;
				end else if (os_cnt != 17'h00000) begin
					os_cnt <= os_cnt - 17'h00001;
					if (os_cnt == 17'h00001) begin
						ring_bit <= 1'b0; // (RULE5)
					end
				end else begin
					// A bit left over from full-wave mode must not linger
					ring_bit <= 1'b0; // (RULE6)
				end
				tag_out <= {~link_down, rd_pend, rd_pend, 2'h0, buf_pop, 6'h00, ~link_down, 3'h0};
				s1_out  <= {1'b0, rd_idx, 12'h000};
				s2_out  <= {rd_data, 4'h0};
				s12_out <= {14'h0000, ring_bit, 5'h00}; // (RULE2)
				// A read answer is offered in one frame only
				rd_pend <= 1'b0;
				if (buf_pop) begin
					s5_out <= {buf_mem[buf_rp], 4'h0}; // (RULE2) (RULE10)
				end
			end

			// The off-hook event overrides whatever count is left
			if (hook_rise && !fullwave) begin
				ring_bit <= 1'b0; // (RULE7)
				os_cnt   <= 17'h00000;
			end

			// Sample buffer; a stalled link lets it fill and stops the producer
			if (buf_push) begin
				buf_mem[buf_wp] <= sample;
				buf_wp          <= ~buf_wp;
			end
			if (buf_pop) begin
				buf_rp <= ~buf_rp;
			end
			if (buf_push && !buf_pop) begin
				buf_cnt <= buf_cnt + 2'h1;
			end else if (buf_pop && !buf_push) begin
				buf_cnt <= buf_cnt - 2'h1;
			end

			// Wake: the bit clock is stopped, so this runs on CLK alone
			if (wake_want) begin
				wake_hold <= 1'b1; // (RULE16)
			end
			if (link_down && sync) begin
				sync_hi <= 1'b1;
			end
			if (sync_hi && !sync) begin
				sync_hi   <= 1'b0;
				link_down <= 1'b0; // (RULE17)
				wake_hold <= 1'b0;
			end

			// Serial input: wake level in low power, frame bits otherwise
			if (link_down) begin
				SDATA_IN <= wake_hold; // (RULE16) (RULE17)
			end else if (rise) begin
				SDATA_IN <= out_bit; // (RULE2)
			end

			// On-hook current ramp for spark quenching
			if (hook_fall && line_ctl[`LC_SLEW]) begin
				ramp_cnt <= `SLEW_RAMP_CYC; // (RULE23)
			end else if (ramp_cnt != 12'h000) begin
				ramp_cnt <= ramp_cnt - 12'h001;
			end
			SLEW_RAMP <= ramp_cnt != 12'h000; // (RULE23)

			// Line side control levels
			THRESH_SEL     <= line_ctl[`LC_THRESH]; // (RULE1)
			RINGER_Z       <= line_ctl[`LC_RINGZ]; // (RULE15)
			DC_TERM        <= dc_termination_select; // (RULE26)
			TX_ATTEN       <= dc_termination_select == `DCT_LOWVOLT; // (RULE22)
			LOWVOLT_MODE   <= (dc_termination_select == `DCT_LOWVOLT) ||
				(dc_termination_select == `DCT_STANDARD && line_ctl2[`LC2_NOATTEN]); // (RULE22)
			// Headroom is refused outside current-limit mode or with high loop current
			HEADROOM_BOOST <= line_ctl2[`LC2_HEADROOM] &&
				dc_termination_select == `DCT_CURLIMIT && loop_current_code < `LCS_HEADROOM; // (RULE21)
		end
	end

endmodule // ring_detect_wake_logic

// ### sim/ring_wake_checker_properties.sv
// Port checks on the ring detect and wake logic
`timescale 1ns/1ps
module ring_wake_checker (
	// Clock and reset
	input wire       CLK,
	input wire       RESETN,
	// Link
	input wire       BIT_CLK,
	input wire       SYNC,
	input wire       SDATA_IN,
	// Line
	input wire [3:0] LOOP_CURRENT,
	input wire       OFF_HOOK,
	input wire [1:0] DC_TERM,
	input wire       LOWVOLT_MODE,
	input wire       TX_ATTEN,
	input wire       HEADROOM_BOOST,
	input wire       SLEW_RAMP
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// Length of the current ramp, counted in clocks
	logic [12:0] ramp_len;
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			ramp_len <= 13'h0;
		else
			ramp_len <= SLEW_RAMP ? ramp_len + 13'h1 : 13'h0;
	end
	reset_term_a: assert property (!$past(RESETN) |-> DC_TERM == 2'h2 && !OFF_HOOK)
		else $error("Wrong line state after reset");
	tx_atten_a: assert property ($stable(DC_TERM) [*2] |-> TX_ATTEN == (DC_TERM == 2'h1))
		else $error("Attenuation does not follow termination");
	lowvolt_mode_a: assert property (($stable(DC_TERM) [*2] ##0 DC_TERM != 2'h2) |-> LOWVOLT_MODE == (DC_TERM == 2'h1))
		else $error("Low voltage mode does not follow termination");
	headroom_mode_a: assert property (($stable(DC_TERM) [*2] ##0 DC_TERM != 2'h3) |-> !HEADROOM_BOOST)
		else $error("Headroom boost outside current limit mode");
	headroom_current_a: assert property (($stable(LOOP_CURRENT) [*6] ##0 LOOP_CURRENT > 4'h5) |-> !HEADROOM_BOOST)
		else $error("Headroom boost at high loop current");
	// A still bit clock and still sync leave nothing that may drop the wake level
	wake_hold_a: assert property ((($stable(BIT_CLK) && $stable(SYNC)) [*8] ##0 SDATA_IN) |=> SDATA_IN)
		else $error("Wake level dropped without warm reset");
	slew_len_a: assert property ($fell(SLEW_RAMP) |-> ramp_len == 13'hfa0)
		else $error("Ramp length wrong");
	slew_cause_a: assert property ($rose(SLEW_RAMP) |-> !OFF_HOOK && ($past(OFF_HOOK) || $past(OFF_HOOK, 2)))
		else $error("Ramp without on-hook transition");
	boost_seen_c: cover property ($rose(HEADROOM_BOOST));
	ramp_seen_c: cover property ($fell(SLEW_RAMP));
	wake_seen_c: cover property ($rose(SDATA_IN) && !BIT_CLK);
endmodule // ring_wake_checker
bind ring_detect_wake_logic ring_wake_checker i_ring_wake_checker (.CLK, .RESETN, .BIT_CLK, .SYNC, .SDATA_IN,
	.LOOP_CURRENT, .OFF_HOOK, .DC_TERM, .LOWVOLT_MODE, .TX_ATTEN, .HEADROOM_BOOST, .SLEW_RAMP);

// ### sim/ctl_model.sv
// Link controller model: sends frames and captures the answer
`timescale 1ns/1ps
module ctl_model (
	// Serial link
	output logic      BIT_CLK,
	output logic      SYNC,
	output logic      SDATA_OUT,
	input  wire logic SDATA_IN
);
	logic [255:0] rx;
	initial begin
		BIT_CLK = 0;
		SYNC = 0;
		SDATA_OUT = 0;
	end
	// Clock runs only in frames; a spare bit picks up the lagging last answer bit
	task automatic frame(input logic [255:0] f);
		for (int i = 0; i < 257; i++) begin
			BIT_CLK = 1;
			SYNC = i < 16;
			SDATA_OUT = i < 256 ? f[255 - i] : ~f[0];
			#40;
			BIT_CLK = 0;
			if (i > 0)
				rx[256 - i] = SDATA_IN;
			#40;
		end
	endtask
	// Warm reset with the bit clock standing still
	task automatic warm();
		SYNC = 1;
		#1000;
		SYNC = 0;
		#1000;
	endtask
endmodule // ctl_model

// ### sim/tb_top.sv
// Self-checking bench for the ring detect and wake logic
`timescale 1ns/1ps
module tb_top;
	// Stimulus
	logic        CLK = 0;
	logic        RESETN = 0;
	logic        RING_POS = 0;
	logic        RING_NEG = 0;
	logic [3:0]  LOOP_CURRENT = 0;
	logic        hk = 0;
	logic [15:0] v, w, es;
	logic [1:0]  ef;
	logic        eb;
	bit          armed = 0;
	int          error_cnt = 0;
	int          compares = 0;
	// Observed
	wire         BIT_CLK, SYNC, SDATA_OUT, SDATA_IN, OFF_HOOK, LINE_MONITOR, THRESH_SEL, RINGER_Z;
	wire         LOWVOLT_MODE, TX_ATTEN, HEADROOM_BOOST, SLEW_RAMP;
	wire [1:0]   DC_TERM;
	wire [255:0] rx = i_ctl_model.rx;
	// Short one-shot keeps the run brief
	ring_detect_wake_logic #(.ONESHOT_FRAMES(2)) i_ring_detect_wake_logic (.CLK, .RESETN, .CE(1'b1), .BIT_CLK,
		.SYNC, .SDATA_OUT, .SDATA_IN, .RING_POS, .RING_NEG, .LOOP_CURRENT, .OFF_HOOK, .LINE_MONITOR,
		.THRESH_SEL, .RINGER_Z, .DC_TERM, .LOWVOLT_MODE, .TX_ATTEN, .HEADROOM_BOOST, .SLEW_RAMP);
	ctl_model i_ctl_model (.BIT_CLK, .SYNC, .SDATA_OUT, .SDATA_IN);
	initial forever #2.5 CLK = ~CLK;
	task automatic complete_run();
		$display("Compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t got %h expected %h", $time, g, e);
		end
	endtask
	function automatic logic [15:0] smp(input logic p, input logic n, input logic f);
		return p ? 16'h7fff : (n || !f) ? 16'h8000 : 16'h04cc;
	endfunction
	function automatic logic [2:0] ctl(input logic [1:0] t, input logic [15:0] c, input logic [3:0] l);
		return {t == 2'h1, t == 2'h1 || (t == 2'h2 && c[1]), t == 2'h3 && c[0] && l < 4'h6};
	endfunction
	// One register access per frame, slot 12 carries the hook state
	task automatic acc(input logic [6:0] a, input logic r, input logic [15:0] d, input logic m = 0);
		@(posedge CLK);
		#1;
		i_ctl_model.frame({16'he008, r, a, 12'h0, d, 4'h0, 180'h0, 13'h0, m, 1'b0, hk, 4'h0});
	endtask
	// Each frame shows what the previous frame saw, so checks trail by one frame
	task automatic ring_chk(input logic m);
		acc(7'h5e, 1, 0, m);
		if (armed) begin
			cmp(rx[159:144], es);
			cmp(rx[5], eb);
			cmp(rx[205:204], ef);
		end
		armed = 0;
	endtask
	task automatic ring(input logic p, input logic n, input logic f, input logic b);
		RING_POS = p;
		RING_NEG = n;
		ring_chk(0);
		es = smp(p, n, f);
		eb = b;
		ef = {n, p};
		armed = 1;
	endtask
	initial begin
		#560000;
		error_cnt++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge CLK);
		#1;
		RESETN = 1;
		void'($urandom(3));
		repeat (4) @(posedge CLK);
		#1;
		cmp(DC_TERM, 2'h2);
		acc(7'h5c, 1, 0);
		acc(7'h70, 1, 0);
		cmp(rx[219:204], 16'h0020);
		w = 16'h0001 | ($urandom & 16'h0002);
		acc(7'h62, 0, w);
		cmp(rx[219:204], 16'h0000);
		for (int d = 1; d < 4; d += 2) begin
			v = ($urandom & 16'h000f) | 16'(d << 4);
			LOOP_CURRENT = d == 3 ? 4'h5 : 4'($urandom);
			acc(7'h5c, 0, v);
			cmp({THRESH_SEL, RINGER_Z, DC_TERM}, {v[1:0], v[5:4]});
			cmp({TX_ATTEN, LOWVOLT_MODE, HEADROOM_BOOST}, ctl(v[5:4], w, LOOP_CURRENT));
		end
		LOOP_CURRENT = 4'h6;
		repeat (10) @(posedge CLK);
		#1;
		cmp(HEADROOM_BOOST, 0);
		acc(7'h5c, 1, 0);
		$display("Test line control done");
		acc(7'h5c, 0, 16'h0028);
		cmp(rx[219:204], v);
		cmp(LOWVOLT_MODE, w[1]);
		ring(0, 1, 0, 0);
		ring(1, 0, 0, 1);
		ring(0, 0, 0, 1);
		ring(0, 0, 0, 0);
		ring(1, 0, 0, 1);
		RING_POS = 0;
		hk = 1;
		ring_chk(0);
		acc(7'h5e, 1, 0, 1);
		cmp(rx[5], 0);
		cmp(rx[250], 0);
		cmp({OFF_HOOK, LINE_MONITOR}, 2'h3);
		hk = 0;
		acc(7'h5c, 0, 16'h002c);
		ring(0, 1, 1, 0);
		ring(0, 0, 1, 1);
		ring(1, 0, 1, 0);
		ring_chk(0);
		$display("Test ring detect done");
		acc(7'h50, 0, 16'h0002);
		acc(7'h52, 0, 16'h0002);
		acc(7'h54, 0, 16'h0000);
		acc(7'h3e, 0, 16'h1000);
		for (int i = 0; i < 100 && SDATA_IN !== 1'b1; i++)
			@(posedge CLK);
		#1;
		cmp(SDATA_IN, 1);
		repeat (200) @(posedge CLK);
		#1;
		cmp(SDATA_IN, 1);
		i_ctl_model.warm();
		acc(7'h54, 1, 0);
		acc(7'h5e, 1, 0);
		cmp(rx[255], 1);
		cmp(rx[205], 1);
		$display("Test wake done");
		complete_run();
	end
endmodule // tb_top
